// [hw/bit_branch_defs.vh]
// constants for the bit-test branch and cpu control execution block
`ifndef BIT_BRANCH_DEFS_VH
`define BIT_BRANCH_DEFS_VH

// operation classes presented by the decoder
`define OP_W 3
`define OP_BIT_SET 3'h0
`define OP_BIT_CLEAR 3'h1
`define OP_CLEAR_IF_SET 3'h2
`define OP_DEC_NONZERO 3'h3
`define OP_INT_ENABLE 3'h4
`define OP_INT_DISABLE 3'h5
`define OP_ZERO_BRANCH 3'h6

// operand selectors
`define SEL_W 3
`define SEL_SADDR 3'h0
`define SEL_SFR 3'h1
`define SEL_ACC 3'h2
`define SEL_PSW 3'h3
`define SEL_PTR_MEM 3'h4
`define SEL_REG_B 3'h5
`define SEL_REG_C 3'h6
`define SEL_NONE 3'h7

// instruction lengths in bytes
`define LEN_W 3
`define LEN_2 3'h2
`define LEN_3 3'h3
`define LEN_4 3'h4

// cpu clock counts, first figure for high-speed ram, second otherwise
`define CLK_W 4
`define CLK_6 4'h6
`define CLK_8 4'h8
`define CLK_9 4'h9
`define CLK_10 4'ha
`define CLK_11 4'hb
`define CLK_12 4'hc
`define CLK_ONE 4'h1

// position of the zero flag inside the program status word
`define PSW_ZERO_BIT 3'h6

// widths
`define ADDR_W 16
`define BYTE_ZERO 8'h00
`define BYTE_ONE 8'h01

`endif

// [hw/bit_test_branch_cpu_control.v]
// execution of bit-test branches, decrement loops and interrupt enable control
`timescale 1ns/1ps
`default_nettype none
`include "bit_branch_defs.vh"

module bit_test_branch_cpu_control (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // decoded instruction request
    input wire start,
    input wire [`OP_W-1:0] op_class,
    input wire [`SEL_W-1:0] operand_sel,
    input wire [2:0] bit_sel,
    input wire [7:0] relative_jump_displacement,
    input wire [`ADDR_W-1:0] instr_addr,
    input wire operand_in_hsram,
    input wire code_from_rom,
    // operand values read by the fetch path
    input wire [7:0] operand_byte,
    input wire [7:0] program_status_word,
    // progress and status
    output wire busy,
    output reg done_q,
    output reg bad_op_q,
    output reg timing_valid_q,
    output reg [`CLK_W-1:0] instr_clocks_q,
    output reg [`LEN_W-1:0] instr_length_q,
    // results
    output reg [`ADDR_W-1:0] next_pc_q,
    output reg branch_taken_q,
    output reg wr_en_q,
    output reg [`SEL_W-1:0] wr_sel_q,
    output reg [7:0] wr_data_q,
    output reg master_interrupt_enable_flag
);

    // length in bytes of each legal form
    function [`LEN_W-1:0] instr_len;
        input [`OP_W-1:0] op;
        input [`SEL_W-1:0] sel;
        begin
            instr_len = `LEN_2;
            case (op)
                `OP_BIT_SET: begin
                    instr_len = (sel == `SEL_SFR) ? `LEN_4 : `LEN_3;
                end
                `OP_BIT_CLEAR: begin
                    case (sel)
                        `SEL_SADDR: instr_len = `LEN_4;
                        `SEL_SFR: instr_len = `LEN_4;
                        `SEL_PSW: instr_len = `LEN_4;
                        default: instr_len = `LEN_3;
                    endcase
                end
                `OP_CLEAR_IF_SET: begin
                    case (sel)
                        `SEL_ACC: instr_len = `LEN_3;
                        `SEL_PTR_MEM: instr_len = `LEN_3;
                        default: instr_len = `LEN_4;
                    endcase
                end
                `OP_DEC_NONZERO: begin
                    instr_len = (sel == `SEL_SADDR) ? `LEN_3 : `LEN_2;
                end
                default: instr_len = `LEN_2;
            endcase
        end
    endfunction

    // cpu clock count; hs picks the high-speed ram figure where one exists
    function [`CLK_W-1:0] instr_clk;
        input [`OP_W-1:0] op;
        input [`SEL_W-1:0] sel;
        input hs;
        begin
            instr_clk = `CLK_6;
            case (op)
                `OP_BIT_SET: begin
                    case (sel)
                        `SEL_SADDR: instr_clk = hs ? `CLK_8 : `CLK_9;
                        `SEL_SFR: instr_clk = `CLK_11;
                        `SEL_ACC: instr_clk = `CLK_8;
                        `SEL_PSW: instr_clk = `CLK_9;
                        default: instr_clk = hs ? `CLK_10 : `CLK_11;
                    endcase
                end
                `OP_BIT_CLEAR: begin
                    case (sel)
                        `SEL_SADDR: instr_clk = hs ? `CLK_10 : `CLK_11;
                        `SEL_SFR: instr_clk = `CLK_11;
                        `SEL_ACC: instr_clk = `CLK_8;
                        `SEL_PSW: instr_clk = `CLK_11;
                        default: instr_clk = hs ? `CLK_10 : `CLK_11;
                    endcase
                end
                `OP_CLEAR_IF_SET: begin
                    case (sel)
                        `SEL_SADDR: instr_clk = hs ? `CLK_10 : `CLK_12;
                        `SEL_SFR: instr_clk = `CLK_12;
                        `SEL_ACC: instr_clk = `CLK_8;
                        `SEL_PSW: instr_clk = `CLK_12;
                        default: instr_clk = hs ? `CLK_10 : `CLK_12;
                    endcase
                end
                `OP_DEC_NONZERO: begin
                    if (sel == `SEL_SADDR) begin
                        instr_clk = hs ? `CLK_8 : `CLK_10;
                    end else begin
                        instr_clk = `CLK_6;
                    end
                end
                default: instr_clk = `CLK_6;
            endcase
        end
    endfunction

    // pc + length + sign-extended displacement, wraps in the 16-bit space
    function [`ADDR_W-1:0] rel_target;
        input [`ADDR_W-1:0] base;
        input [`LEN_W-1:0] len;
        input [7:0] disp;
        reg [`ADDR_W-1:0] ext;
        begin
            ext = {{8{disp[7]}}, disp};
            rel_target = base + {{(`ADDR_W-`LEN_W){1'b0}}, len} + ext;
        end
    endfunction

    // pc of the following instruction when no branch is taken
    function [`ADDR_W-1:0] seq_target;
        input [`ADDR_W-1:0] base;
        input [`LEN_W-1:0] len;
        begin
            seq_target = base + {{(`ADDR_W-`LEN_W){1'b0}}, len};
        end
    endfunction

    // legality of an operation and operand pair
    function legal_pair;
        input [`OP_W-1:0] op;
        input [`SEL_W-1:0] sel;
        begin
            legal_pair = 1'b0;
            case (op)
                `OP_BIT_SET, `OP_BIT_CLEAR, `OP_CLEAR_IF_SET: begin
                    legal_pair = (sel <= `SEL_PTR_MEM);
                end
                `OP_DEC_NONZERO: begin
                    legal_pair = (sel == `SEL_SADDR) || (sel == `SEL_REG_B) || (sel == `SEL_REG_C);
                end
                `OP_INT_ENABLE, `OP_INT_DISABLE, `OP_ZERO_BRANCH: begin
                    legal_pair = 1'b1;
                end
                default: legal_pair = 1'b0;
            endcase
        end
    endfunction

    wire timer_running;
    wire timer_expire;
    wire accept;

    // combinational evaluation of the request in its start cycle
    reg [7:0] src_byte;
    reg tested_bit;
    reg [7:0] dec_byte;
    reg take_d;
    reg wr_d;
    reg [7:0] wdata_d;
    reg [`LEN_W-1:0] len_d;
    reg [`CLK_W-1:0] clk_d;
    reg legal_d;

    // results held until the last clock of the instruction
    reg [`ADDR_W-1:0] pend_pc_q;
    reg pend_take_q;
    reg pend_wr_q;
    reg [`SEL_W-1:0] pend_sel_q;
    reg [7:0] pend_data_q;
    reg [`OP_W-1:0] pend_op_q;
    reg pend_legal_q;
    reg pend_rom_q;

    // a new request is taken only while no instruction is in flight
    assign accept = start && !timer_running;
    assign busy = timer_running;

    // pick the tested byte; the status word always comes from its own port
    always @* begin
        src_byte = operand_byte;
        if (operand_sel == `SEL_PSW) begin
            src_byte = program_status_word;
        end
        tested_bit = src_byte[bit_sel];
        dec_byte = operand_byte - `BYTE_ONE;
    end

    // branch decision and write-back data
    always @* begin
        legal_d = legal_pair(op_class, operand_sel);
        len_d = instr_len(op_class, operand_sel);
        clk_d = instr_clk(op_class, operand_sel, operand_in_hsram);
        take_d = 1'b0;
        wr_d = 1'b0;
        wdata_d = src_byte;
        case (op_class)
            `OP_BIT_SET: begin
                take_d = tested_bit;
            end
            `OP_BIT_CLEAR: begin
                take_d = !tested_bit;
            end
            `OP_CLEAR_IF_SET: begin
                // clearing a status bit replaces the whole word, flags included
                take_d = tested_bit;
                wr_d = tested_bit;
                wdata_d = src_byte & ~(`BYTE_ONE << bit_sel);
            end
            `OP_DEC_NONZERO: begin
                // decrement first, then test the new value
                wr_d = 1'b1;
                wdata_d = dec_byte;
                take_d = (dec_byte != `BYTE_ZERO);
            end
            `OP_ZERO_BRANCH: begin
                take_d = program_status_word[`PSW_ZERO_BIT];
            end
            default: begin
                take_d = 1'b0;
            end
        endcase
        // an illegal pair runs its clocks but changes nothing
        if (!legal_d) begin
            take_d = 1'b0;
            wr_d = 1'b0;
        end
    end

    // instruction timer, one tick per cpu clock
    cycle_timer u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(accept),
        .load_val(clk_d - `CLK_ONE),
        .running(timer_running),
        .expire(timer_expire)
    );

    // capture the outcome when the request is taken
    always @(posedge clk) begin
        if (sys_rst) begin
            pend_pc_q <= {`ADDR_W{1'b0}};
            pend_take_q <= 1'b0;
            pend_wr_q <= 1'b0;
            pend_sel_q <= `SEL_NONE;
            pend_data_q <= `BYTE_ZERO;
            pend_op_q <= `OP_BIT_SET;
            pend_legal_q <= 1'b0;
            pend_rom_q <= 1'b0;
        end else if (accept) begin
            pend_pc_q <= take_d ? rel_target(instr_addr, len_d, relative_jump_displacement)
                                : seq_target(instr_addr, len_d);
            pend_take_q <= take_d;
            pend_wr_q <= wr_d;
            pend_sel_q <= operand_sel;
            pend_data_q <= wdata_d;
            pend_op_q <= op_class;
            pend_legal_q <= legal_d;
            pend_rom_q <= code_from_rom;
        end
    end

    // length and clock count of the instruction being run, shown at once
    always @(posedge clk) begin
        if (sys_rst) begin
            instr_clocks_q <= {`CLK_W{1'b0}};
            instr_length_q <= {`LEN_W{1'b0}};
        end else if (accept) begin
            instr_clocks_q <= clk_d;
            instr_length_q <= len_d;
        end
    end

    // retire on the last clock: pc, write-back and status appear together
    always @(posedge clk) begin
        if (sys_rst) begin
            done_q <= 1'b0;
            wr_en_q <= 1'b0;
            bad_op_q <= 1'b0;
            next_pc_q <= {`ADDR_W{1'b0}};
            branch_taken_q <= 1'b0;
            wr_sel_q <= `SEL_NONE;
            wr_data_q <= `BYTE_ZERO;
            timing_valid_q <= 1'b0;
        end else begin
            done_q <= timer_expire;
            wr_en_q <= timer_expire && pend_wr_q;
            bad_op_q <= timer_expire && !pend_legal_q;
            if (timer_expire) begin
                next_pc_q <= pend_pc_q;
                branch_taken_q <= pend_take_q;
                wr_sel_q <= pend_sel_q;
                wr_data_q <= pend_data_q;
                // code from other memory runs, but its clock count is not guaranteed
                timing_valid_q <= pend_rom_q;
            end
        end
    end

    // master interrupt enable changes as the instruction retires
    always @(posedge clk) begin
        if (sys_rst) begin
            master_interrupt_enable_flag <= 1'b0;
        end else if (timer_expire && pend_legal_q) begin
            if (pend_op_q == `OP_INT_ENABLE) begin
                master_interrupt_enable_flag <= 1'b1;
            end else if (pend_op_q == `OP_INT_DISABLE) begin
                master_interrupt_enable_flag <= 1'b0;
            end
        end
    end

endmodule // bit_test_branch_cpu_control

`default_nettype wire

// [hw/cycle_timer.v]
// down counter that marks the last cpu clock of an instruction
`timescale 1ns/1ps
`default_nettype none
`include "bit_branch_defs.vh"

module cycle_timer (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // control
    input wire load,
    input wire [`CLK_W-1:0] load_val,
    // status
    output wire running,
    output wire expire
);

    reg [`CLK_W-1:0] cnt_q;
    reg [`CLK_W-1:0] cnt_d;

    // next count: load wins, otherwise count down to zero
    always @* begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = load_val;
        end else if (cnt_q != {`CLK_W{1'b0}}) begin
            cnt_d = cnt_q - `CLK_ONE;
        end
    end

    // counter register
    always @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= {`CLK_W{1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign running = (cnt_q != {`CLK_W{1'b0}});
    assign expire = (cnt_q == `CLK_ONE); // last counted clock before done

endmodule // cycle_timer

`default_nettype wire

// [test/bit_branch_properties.sv]
// concurrent checks on the ports of the bit-test branch execution block
`timescale 1ns/1ps
`default_nettype none
module bit_branch_properties (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // request side
    input wire logic start,
    input wire logic [2:0] op_class,
    input wire logic [2:0] operand_sel,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] relative_jump_displacement,
    input wire logic [15:0] instr_addr,
    input wire logic code_from_rom,
    input wire logic [7:0] operand_byte,
    input wire logic [7:0] program_status_word,
    // result side
    input wire logic busy,
    input wire logic done_q,
    input wire logic timing_valid_q,
    input wire logic [3:0] instr_clocks_q,
    input wire logic [2:0] instr_length_q,
    input wire logic [15:0] next_pc_q,
    input wire logic branch_taken_q,
    input wire logic wr_en_q,
    input wire logic [7:0] wr_data_q,
    input wire logic master_interrupt_enable_flag
);
    logic acc_w;
    logic bit_v;
    logic rom_h;
    logic [3:0] cnt_q;
    logic [2:0] op_h;
    logic [2:0] bit_h;
    logic [7:0] src_h;
    logic [7:0] disp_h;
    logic [15:0] addr_h;
    assign acc_w = start && !busy;
    assign bit_v = src_h[bit_h];
    // hold the accepted request so retire values can be tied back to their cause
    always @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= 4'h0;
        end else if (acc_w) begin
            cnt_q <= 4'h1;
        end else if (done_q) begin
            cnt_q <= 4'h0;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q + 4'h1;
        end
        if (acc_w) begin
            op_h <= op_class;
            bit_h <= (op_class == 3'h6) ? 3'h6 : bit_sel;
            src_h <= (operand_sel == 3'h3 || op_class == 3'h6) ? program_status_word : operand_byte;
            disp_h <= relative_jump_displacement;
            addr_h <= instr_addr;
            rom_h <= code_from_rom;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_accept;
        start && !busy;
    endsequence
    // shortest count is 6 and longest 12 clocks
    sequence s_retire;
        !done_q [*5] ##[1:7] done_q;
    endsequence
    accept_busy_a: assert property (s_accept |=> busy && !done_q)
        else $error("busy not raised after accept");
    retire_window_a: assert property (s_accept |=> s_retire)
        else $error("retire outside 6 to 12 clocks");
    clock_count_a: assert property (done_q |-> cnt_q == instr_clocks_q)
        else $error("retire cycle differs from clock count");
    short_ctrl_a: assert property (start && !busy && op_class >= 3'h4 && op_class <= 3'h6 |=>
        instr_clocks_q == 4'h6 && instr_length_q == 3'h2) else $error("control form length or count wrong");
    target_pc_a: assert property (done_q |-> next_pc_q == addr_h + {13'h0, instr_length_q} +
        (branch_taken_q ? {{8{disp_h[7]}}, disp_h} : 16'h0)) else $error("next pc wrong");
    set_test_a: assert property (done_q && op_h == 3'h0 |-> branch_taken_q == bit_v && !wr_en_q)
        else $error("set test branch wrong");
    clear_test_a: assert property (done_q && op_h == 3'h1 |-> branch_taken_q == !bit_v && !wr_en_q)
        else $error("clear test branch wrong");
    clear_write_a: assert property (done_q && op_h == 3'h2 |-> branch_taken_q == bit_v && wr_en_q == bit_v &&
        (!bit_v || wr_data_q == (src_h & ~(8'h01 << bit_h)))) else $error("test and clear wrong");
    dec_branch_a: assert property (done_q && op_h == 3'h3 |-> wr_en_q && wr_data_q == src_h - 8'h01 &&
        branch_taken_q == (src_h != 8'h01)) else $error("decrement branch wrong");
    int_on_a: assert property (done_q && op_h == 3'h4 |-> master_interrupt_enable_flag)
        else $error("enable flag not set");
    int_off_a: assert property (done_q && op_h == 3'h5 |-> !master_interrupt_enable_flag)
        else $error("enable flag not cleared");
    flag_hold_a: assert property (!done_q |-> $stable(master_interrupt_enable_flag))
        else $error("enable flag moved outside retire");
    zero_branch_a: assert property (done_q && op_h == 3'h6 |-> branch_taken_q == bit_v)
        else $error("zero flag branch wrong");
    rom_flag_a: assert property (done_q |-> timing_valid_q == rom_h)
        else $error("timing valid flag wrong");
endmodule // bit_branch_properties
`default_nettype wire

// [test/bit_test_branch_cpu_control_tb.sv]
// self-checking bench for the bit-test branch execution block
`timescale 1ns/1ps
`default_nettype none
module bit_test_branch_cpu_control_tb;
    logic clk, sys_rst, start, operand_in_hsram, code_from_rom, busy, done_q, bad_op_q, timing_valid_q;
    logic [2:0] op_class, operand_sel, bit_sel, instr_length_q, wr_sel_q, ld_sel;
    logic [7:0] relative_jump_displacement, operand_byte, program_status_word, wr_data_q, ld_data;
    logic [15:0] instr_addr, next_pc_q;
    logic [3:0] instr_clocks_q;
    logic branch_taken_q, wr_en_q, master_interrupt_enable_flag, ld_en;
    int seed, err_total, checks_done, mie_e, op, sel;
    int mir [0:7];
    int exp_q [$];
    bit_test_branch_cpu_control dut_u (.clk(clk), .sys_rst(sys_rst), .start(start), .op_class(op_class),
        .operand_sel(operand_sel), .bit_sel(bit_sel), .relative_jump_displacement(relative_jump_displacement),
        .instr_addr(instr_addr), .operand_in_hsram(operand_in_hsram), .code_from_rom(code_from_rom),
        .operand_byte(operand_byte), .program_status_word(program_status_word), .busy(busy), .done_q(done_q),
        .bad_op_q(bad_op_q), .timing_valid_q(timing_valid_q), .instr_clocks_q(instr_clocks_q),
        .instr_length_q(instr_length_q), .next_pc_q(next_pc_q), .branch_taken_q(branch_taken_q),
        .wr_en_q(wr_en_q), .wr_sel_q(wr_sel_q), .wr_data_q(wr_data_q),
        .master_interrupt_enable_flag(master_interrupt_enable_flag));
    operand_store_model mem_u (.clk(clk), .operand_sel(operand_sel), .operand_byte(operand_byte),
        .program_status_word(program_status_word), .wr_en_q(wr_en_q), .wr_sel_q(wr_sel_q),
        .wr_data_q(wr_data_q), .ld_en(ld_en), .ld_sel(ld_sel), .ld_data(ld_data));
    // free running cpu clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task report_and_stop;
        if (err_total == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task check(input logic [15:0] seen, input int exp);
        checks_done++;
        if (seen !== exp[15:0]) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp[15:0]);
        end
    endtask
    // length and both clock figures packed as len, first, second; 0 means no figure
    function automatic int tbl(input int o, input int s);
        case (o * 8 + s)
            0: return 12'h389;
            1: return 12'h40b;
            2, 10, 18: return 12'h380;
            3: return 12'h309;
            4, 12: return 12'h3ab;
            8: return 12'h4ab;
            9, 11: return 12'h40b;
            16: return 12'h4ac;
            17, 19: return 12'h40c;
            20: return 12'h3ac;
            24: return 12'h38a;
            29, 30: return 12'h260;
            default: return 12'h206;
        endcase
    endfunction
    // one instruction: issue, hold a refused start while busy, preload, then compare at retire
    task automatic run_op(input int o, input int s, input int ls, input int ld);
        int t, f, sc, e_clk, src, b, bv, tk, we, wd, n;
        start = 1'b1;
        op_class = o[2:0];
        operand_sel = s[2:0];
        {bit_sel, relative_jump_displacement, instr_addr, operand_in_hsram, code_from_rom} = $random(seed);
        t = tbl(o, s);
        f = (t >> 4) & 15;
        sc = t & 15;
        e_clk = (f == 0) ? sc : (sc == 0) ? f : (operand_in_hsram ? f : sc);
        src = (s == 3 || o == 6) ? mir[3] : mir[s];
        b = (o == 6) ? 6 : bit_sel;
        bv = (src >> b) & 1;
        tk = (o == 1) ? !bv : (o == 3) ? (((src - 1) & 255) != 0) : (o == 4 || o == 5 || o == 7) ? 0 : bv;
        we = (o == 2 && bv) || o == 3;
        wd = (o == 3) ? ((src - 1) & 255) : (src & ~(1 << b) & 255);
        exp_q.push_back((instr_addr + (t >> 8) + (tk ? int'($signed(relative_jump_displacement)) : 0)) & 16'hffff);
        exp_q.push_back(tk);
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (n == 1) begin
                check(instr_clocks_q, e_clk);
                check(instr_length_q, t >> 8);
                {op_class, operand_sel} = $random(seed);
                ld_en = 1'b1;
                ld_sel = (ls < 0) ? $unsigned($random(seed)) % 7 : ls;
                ld_data = (ls < 0) ? $random(seed) : ld;
                mir[ld_sel] = ld_data;
            end else if (n == 2) begin
                start = 1'b0;
                ld_en = 1'b0;
            end
        end while (done_q !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            $display("ERROR at %0t: no retire", $time);
            report_and_stop;
        end else begin
            mie_e = (o == 4) ? 1 : (o == 5) ? 0 : mie_e;
            check(n, e_clk);
            check(next_pc_q, exp_q.pop_front());
            check(branch_taken_q, exp_q.pop_front());
            check(wr_en_q, we);
            check(bad_op_q, o == 7);
            check(timing_valid_q, code_from_rom);
            check(master_interrupt_enable_flag, mie_e);
            if (we) begin
                check({wr_sel_q, wr_data_q}, s * 256 + wd);
                mir[s] = wd;
            end
        end
    endtask
    // main sequence: reset, sweep of the three bit-test ops over their five operands, loop boundary, then random traffic back to back
    initial begin
        {seed, err_total, checks_done, mie_e} = {32'd65, 96'd0};
        for (int i = 0; i < 8; i++) begin
            mir[i] = 0;
        end
        {sys_rst, start, op_class, operand_sel, bit_sel, relative_jump_displacement} = {1'b1, 18'h0};
        {instr_addr, operand_in_hsram, code_from_rom, ld_en, ld_sel, ld_data} = 30'h0;
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        check({busy, done_q, master_interrupt_enable_flag, wr_sel_q}, 7);
        for (op = 0; op < 3; op++) begin
            for (sel = 0; sel < 5; sel++) begin
                repeat (4) run_op(op, sel, -1, 0);
            end
        end
        run_op(4, 7, 6, 1);
        run_op(3, 6, -1, 0);
        run_op(5, 7, -1, 0);
        run_op(7, 7, -1, 0);
        repeat (300) begin
            op = $unsigned($random(seed)) % 7;
            sel = $unsigned($random(seed)) % ((op < 3) ? 5 : 3);
            sel = (op < 3) ? sel : (op > 3) ? 7 : (sel == 0) ? 0 : sel + 4;
            run_op(op, sel, -1, 0);
        end
        report_and_stop;
    end
endmodule // bit_test_branch_cpu_control_tb
bind bit_test_branch_cpu_control bit_branch_properties chk_u (.clk(clk), .sys_rst(sys_rst), .start(start),
    .op_class(op_class), .operand_sel(operand_sel), .bit_sel(bit_sel), .instr_addr(instr_addr),
    .relative_jump_displacement(relative_jump_displacement), .code_from_rom(code_from_rom),
    .operand_byte(operand_byte), .program_status_word(program_status_word), .busy(busy), .done_q(done_q),
    .timing_valid_q(timing_valid_q), .instr_clocks_q(instr_clocks_q), .instr_length_q(instr_length_q),
    .next_pc_q(next_pc_q), .branch_taken_q(branch_taken_q), .wr_en_q(wr_en_q), .wr_data_q(wr_data_q),
    .master_interrupt_enable_flag(master_interrupt_enable_flag));
`default_nettype wire

// [test/operand_store_model.sv]
// data memory and register model that feeds operand bytes and takes write-backs
`timescale 1ns/1ps
`default_nettype none
module operand_store_model (
    // clock
    input wire logic clk,
    // operand selection
    input wire logic [2:0] operand_sel,
    output logic [7:0] operand_byte,
    output logic [7:0] program_status_word,
    // write-back from the block
    input wire logic wr_en_q,
    input wire logic [2:0] wr_sel_q,
    input wire logic [7:0] wr_data_q,
    // preload from the bench
    input wire logic ld_en,
    input wire logic [2:0] ld_sel,
    input wire logic [7:0] ld_data
);
    logic [7:0] store_q [0:7];
    initial begin
        for (int i = 0; i < 8; i++) begin
            store_q[i] = 8'h00;
        end
    end
    // an unselected slot reads inverted so a stale byte is never mistaken for data;
    // a write-back still in flight is forwarded, since a back-to-back start samples at that very edge
    assign operand_byte = (wr_en_q && wr_sel_q == operand_sel) ? wr_data_q
        : (operand_sel == 3'h7) ? ~store_q[0] : store_q[operand_sel];
    assign program_status_word = (wr_en_q && wr_sel_q == 3'h3) ? wr_data_q : store_q[3];
    // write-back and preload never share an edge in the bench's sequence
    always @(posedge clk) begin
        if (wr_en_q) begin
            store_q[wr_sel_q] <= wr_data_q;
        end
        if (ld_en) begin
            store_q[ld_sel] <= ld_data;
        end
    end
endmodule // operand_store_model
`default_nettype wire
